// >>> rtl/tpu_map.svh
// register map, field positions, reset values and timing counts
// Functional notes
// - comparator output can feed capture channel zero
// - comparator routing withholds channel zero pin
// - clock select 1:1 picks external clock pin
// - external clock pin shareable with modulo timer
// - prescaler divides by 1 to 128
// - 16-bit counter, up or up/down
// - 16-bit modulus bounds the count range
// - modulus all zeros or ones runs free
// - counter readable without disturbing the count
// - any counter write resets the counter
// - channel is capture, compare or edge PWM
// - capture on rising, falling or either edge
// - compare match sets, clears or toggles output
// - PWM output polarity is selectable
// - center-aligned mode applies to all channels
// - channel interrupt plus overflow interrupt
// - after reset timer disabled, pin follows port settings
// - external clock synchronised to bus clock
// - timer-owned pin ignores port data settings
// - clock select: none, bus, fixed, external
// - overflow flag at wrap or turn down
`ifndef TPU_MAP_SVH
`define TPU_MAP_SVH
`define TPU_ADDR_SC      8'h00
`define TPU_ADDR_CNT     8'h04
`define TPU_ADDR_MOD     8'h08
`define TPU_ADDR_CHSC    8'h0c
`define TPU_ADDR_CHVAL   8'h10
`define TPU_ADDR_OPT2    8'h14
`define TPU_SC_FLAG      7
`define TPU_SC_TOIE      6
`define TPU_SC_CENTER_ALIGNED_PWM      5
`define TPU_SC_CLKS_HI   4
`define TPU_SC_CLKS_LO   3
`define TPU_SC_PS_HI     2
`define TPU_CH_FLAG      7
`define TPU_CH_IE        6
`define TPU_CH_MS_HI     5
`define TPU_CH_MS_LO     4
`define TPU_CH_ELS_HI    3
`define TPU_CH_ELS_LO    2
`define TPU_OPT2_COMPARATOR_TO_CAPTURE_SELECT    0
`define TPU_CLKS_NONE    2'h0
`define TPU_CLKS_BUS     2'h1
`define TPU_CLKS_FIXED   2'h2
`define TPU_CLKS_EXT     2'h3
`define TPU_RST_BYTE     8'h00
`define TPU_RST_WORD     16'h0000
`define TPU_CNT_FULL     16'hffff
`define TPU_PRESC_W      7
`endif

// >>> rtl/tpu_pkg.sv
// types shared by the timer and PWM unit
package tpu_pkg;
    typedef enum logic [1:0] {
        TPU_CH_CAPTURE,
        TPU_CH_COMPARE,
        TPU_CH_EPWM,
        TPU_CH_CENTER_ALIGNED_PWM
    } tpu_chmode_t;
endpackage

// >>> rtl/tpu_timer_pwm.sv
// timer and PWM unit, one channel, with AHB-Lite register slave
`timescale 1ns/1ps
`default_nettype none
`include "tpu_map.svh"
module tpu_timer_pwm (
    input  wire logic        ref_clk,      // bus clock
    input  wire logic        rst_n,        // async reset, active low
    input  wire logic        hsel,         // slave select
    input  wire logic [31:0] haddr,        // byte address
    input  wire logic [1:0]  htrans,       // transfer type
    input  wire logic        hwrite,       // write when high
    input  wire logic [2:0]  hsize,        // word only
    input  wire logic [31:0] hwdata,       // write data
    input  wire logic        hready,       // bus ready in
    output logic      [31:0] hrdata,       // read data
    output logic             hreadyout,    // slave ready
    output logic             hresp,        // always okay
    input  wire logic        ext_clk_pin,  // external count clock
    input  wire logic        fixed_clk,    // fixed system clock
    input  wire logic        cmp_out,      // analog comparator output
    input  wire logic        ch_pin_i,     // channel zero pin level
    output logic             ch_pin_o,     // channel zero pin drive
    output logic             ch_pin_oe,    // channel zero pin enable
    input  wire logic        port_data,    // general port data
    input  wire logic        port_dir,     // general port direction
    output logic             timer_owns,   // pin taken by timer
    output logic             ovf_irq,      // overflow interrupt
    output logic             ch_irq        // channel interrupt
);
    // ---------------- bus slave ----------------
    logic        ap_wr_r;
    logic        ap_rd_r;
    logic [7:0]  ap_addr_r;
    logic [31:0] hrdata_r;
    logic [31:0] rd_nxt;
    logic        addr_ok;
    logic        wr_sc;
    logic        wr_cnt;
    logic        wr_mod;
    logic        wr_chsc;
    logic        wr_chval;
    logic        wr_opt2;

    // timer state
    logic        flag_r;
    logic        flag_arm_r;
    logic        toie_r;
    logic        center_aligned_pwm_r;
    logic [1:0]  clks_r;
    logic [2:0]  ps_r;
    logic [15:0] cnt_r;
    logic        dn_r;
    logic [15:0] mod_r;
    logic [6:0]  pre_r;
    logic        chf_r;
    logic        chf_arm_r;
    logic        chie_r;
    logic [1:0]  ms_r;
    logic [1:0]  els_r;
    logic [15:0] chbuf_r;
    logic [15:0] chval_r;
    logic        chout_r;
    logic        comparator_to_capture_select_r;

    // synchronisers
    logic [1:0]  ext_s_r;
    logic        ext_d_r;
    logic [1:0]  fix_s_r;
    logic        fix_d_r;
    logic [1:0]  pin_s_r;
    logic [1:0]  cmp_s_r;
    logic        cap_d_r;

    logic        src_tick;
    logic        tick;
    logic [15:0] top;
    logic        ovf_evt;
    logic        cap_in;
    logic        cap_evt;
    logic        cmp_evt;
    logic        pwm_on;
    tpu_pkg::tpu_chmode_t chmode;

    function automatic logic [6:0] presc_mask(input logic [2:0] ps);
        presc_mask = 7'((8'h01 << ps) - 8'h01);
    endfunction

    function automatic logic [15:0] top_of(input logic [15:0] m);
        if (m == `TPU_RST_WORD || m == `TPU_CNT_FULL) begin
            top_of = `TPU_CNT_FULL;
        end else begin
            top_of = m;
        end
    endfunction

    assign hreadyout = 1'b1;
    assign hresp     = 1'b0;
    assign hrdata    = hrdata_r;

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            ap_wr_r   <= 1'b0;
            ap_rd_r   <= 1'b0;
            ap_addr_r <= `TPU_RST_BYTE;
        end else if (hready) begin
            ap_wr_r   <= hsel && htrans[1] && hwrite;
            ap_rd_r   <= hsel && htrans[1] && !hwrite;
            ap_addr_r <= haddr[7:0];
        end
    end

    assign addr_ok  = (haddr[31:8] == 24'h000000);
    assign wr_sc    = ap_wr_r && ap_addr_r == `TPU_ADDR_SC;
    assign wr_cnt   = ap_wr_r && ap_addr_r == `TPU_ADDR_CNT;
    assign wr_mod   = ap_wr_r && ap_addr_r == `TPU_ADDR_MOD;
    assign wr_chsc  = ap_wr_r && ap_addr_r == `TPU_ADDR_CHSC;
    assign wr_chval = ap_wr_r && ap_addr_r == `TPU_ADDR_CHVAL;
    assign wr_opt2  = ap_wr_r && ap_addr_r == `TPU_ADDR_OPT2;

    // read data is sampled at the address phase; unmapped reads give zero
    always_comb begin
        rd_nxt = 32'h00000000;
        if (addr_ok) begin
            case (haddr[7:0])
                `TPU_ADDR_SC:    rd_nxt = {24'h000000, flag_r, toie_r,
                                           center_aligned_pwm_r, clks_r, ps_r};
                `TPU_ADDR_CNT:   rd_nxt = {16'h0000, cnt_r};
                `TPU_ADDR_MOD:   rd_nxt = {16'h0000, mod_r};
                `TPU_ADDR_CHSC:  rd_nxt = {24'h000000, chf_r, chie_r,
                                           ms_r, els_r, 2'h0};
                `TPU_ADDR_CHVAL: rd_nxt = {16'h0000, chval_r};
                `TPU_ADDR_OPT2:  rd_nxt = {31'h00000000, comparator_to_capture_select_r};
                default:         rd_nxt = 32'h00000000;
            endcase
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            hrdata_r <= 32'h00000000;
        end else if (hready && hsel && htrans[1] && !hwrite) begin
            hrdata_r <= rd_nxt;
        end
    end

    // ---------------- control registers ----------------
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            toie_r <= 1'b0;
            center_aligned_pwm_r <= 1'b0;
            clks_r <= `TPU_CLKS_NONE;
            ps_r   <= 3'h0;
            mod_r  <= `TPU_RST_WORD;
            chie_r <= 1'b0;
            ms_r   <= 2'h0;
            els_r  <= 2'h0;
            comparator_to_capture_select_r <= 1'b0;
        end else begin
            if (wr_sc) begin
                toie_r <= hwdata[`TPU_SC_TOIE];
                center_aligned_pwm_r <= hwdata[`TPU_SC_CENTER_ALIGNED_PWM];
                clks_r <= hwdata[`TPU_SC_CLKS_HI:`TPU_SC_CLKS_LO];
                ps_r   <= hwdata[`TPU_SC_PS_HI:0];
            end
            if (wr_mod) begin
                mod_r <= hwdata[15:0];
            end
            if (wr_chsc) begin
                chie_r <= hwdata[`TPU_CH_IE];
                ms_r   <= hwdata[`TPU_CH_MS_HI:`TPU_CH_MS_LO];
                els_r  <= hwdata[`TPU_CH_ELS_HI:`TPU_CH_ELS_LO];
            end
            if (wr_opt2) begin
                comparator_to_capture_select_r <= hwdata[`TPU_OPT2_COMPARATOR_TO_CAPTURE_SELECT];
            end
        end
    end

    // ---------------- clock source and prescaler ----------------
    // the external pin is only sampled here, so a modulo timer elsewhere
    // may watch the same pin at the same time
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            ext_s_r <= 2'h0;
            ext_d_r <= 1'b0;
            fix_s_r <= 2'h0;
            fix_d_r <= 1'b0;
        end else begin
            ext_s_r <= {ext_s_r[0], ext_clk_pin};
            ext_d_r <= ext_s_r[1];
            fix_s_r <= {fix_s_r[0], fixed_clk};
            fix_d_r <= fix_s_r[1];
        end
    end

    always_comb begin
        case (clks_r)
            `TPU_CLKS_BUS:   src_tick = 1'b1;
            `TPU_CLKS_FIXED: src_tick = fix_s_r[1] && !fix_d_r;
            `TPU_CLKS_EXT:   src_tick = ext_s_r[1] && !ext_d_r;
            default:         src_tick = 1'b0;
        endcase
    end

    // one pulse per 2^ps source edges
    assign tick = src_tick &&
                  ((pre_r & presc_mask(ps_r)) == presc_mask(ps_r));

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            pre_r <= 7'h00;
        end else if (wr_cnt) begin
            pre_r <= 7'h00;
        end else if (src_tick) begin
            pre_r <= pre_r + 7'h01;
        end
    end

    // ---------------- counter ----------------
    assign top = top_of(mod_r);
    assign ovf_evt = tick && !wr_cnt && cnt_r == top &&
                     (!center_aligned_pwm_r || !dn_r);

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt_r <= `TPU_RST_WORD;
            dn_r  <= 1'b0;
        end else if (wr_cnt) begin
            cnt_r <= `TPU_RST_WORD;
            dn_r  <= 1'b0;
        end else if (tick) begin
            if (!center_aligned_pwm_r) begin
                dn_r  <= 1'b0;
                cnt_r <= (cnt_r == top) ? `TPU_RST_WORD : cnt_r + 16'h0001;
            end else if (dn_r) begin
                if (cnt_r == `TPU_RST_WORD) begin
                    dn_r  <= 1'b0;
                    cnt_r <= cnt_r + 16'h0001;
                end else begin
                    cnt_r <= cnt_r - 16'h0001;
                end
            end else if (cnt_r == top) begin
                dn_r  <= 1'b1;
                cnt_r <= cnt_r - 16'h0001;
            end else begin
                cnt_r <= cnt_r + 16'h0001;
            end
        end
    end

    // overflow flag: read while set arms the clear; a new overflow
    // disarms the clear, so the second event is never lost
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            flag_r     <= 1'b0;
            flag_arm_r <= 1'b0;
        end else if (ovf_evt) begin
            flag_r     <= 1'b1;
            flag_arm_r <= 1'b0;
        end else begin
            if (hready && hsel && htrans[1] && !hwrite &&
                haddr[7:0] == `TPU_ADDR_SC && flag_r) begin
                flag_arm_r <= 1'b1;
            end
            if (wr_sc && !hwdata[`TPU_SC_FLAG] && flag_arm_r) begin
                flag_r     <= 1'b0;
                flag_arm_r <= 1'b0;
            end
        end
    end

    // ---------------- channel zero ----------------
    always_comb begin
        if (center_aligned_pwm_r) begin
            chmode = tpu_pkg::TPU_CH_CENTER_ALIGNED_PWM;
        end else if (ms_r[1]) begin
            chmode = tpu_pkg::TPU_CH_EPWM;
        end else if (ms_r[0]) begin
            chmode = tpu_pkg::TPU_CH_COMPARE;
        end else begin
            chmode = tpu_pkg::TPU_CH_CAPTURE;
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            pin_s_r <= 2'h0;
            cmp_s_r <= 2'h0;
            cap_d_r <= 1'b0;
        end else begin
            pin_s_r <= {pin_s_r[0], ch_pin_i};
            cmp_s_r <= {cmp_s_r[0], cmp_out};
            cap_d_r <= cap_in;
        end
    end

    assign cap_in = comparator_to_capture_select_r ? cmp_s_r[1] : pin_s_r[1];
    assign cap_evt = chmode == tpu_pkg::TPU_CH_CAPTURE && !wr_cnt &&
                     ((els_r[0] && cap_in && !cap_d_r) ||
                      (els_r[1] && !cap_in && cap_d_r));
    assign cmp_evt = chmode == tpu_pkg::TPU_CH_COMPARE && tick &&
                     !wr_cnt && cnt_r == chval_r;
    // active phase while below the duty value, both PWM kinds
    assign pwm_on  = cnt_r < chval_r;

    // pwm duty is buffered and taken at the overflow so no glitch
    // cycle appears when software changes it mid-period
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            chbuf_r <= `TPU_RST_WORD;
            chval_r <= `TPU_RST_WORD;
        end else begin
            if (wr_chval) begin
                chbuf_r <= hwdata[15:0];
            end
            if (cap_evt) begin
                chval_r <= cnt_r;
            end else if (chmode == tpu_pkg::TPU_CH_COMPARE && wr_chval) begin
                chval_r <= hwdata[15:0];
            end else if (chmode[1] && (ovf_evt || clks_r == 2'h0)) begin
                chval_r <= chbuf_r;
            end
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            chout_r <= 1'b0;
        end else if (chmode[1]) begin
            chout_r <= pwm_on ^ els_r[0];
        end else if (cmp_evt) begin
            case (els_r)
                2'h1:    chout_r <= !chout_r;
                2'h2:    chout_r <= 1'b0;
                2'h3:    chout_r <= 1'b1;
                default: chout_r <= chout_r;
            endcase
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            chf_r     <= 1'b0;
            chf_arm_r <= 1'b0;
        end else if (cap_evt || cmp_evt ||
                     (chmode[1] && tick && cnt_r == chval_r)) begin
            chf_r     <= 1'b1;
            chf_arm_r <= 1'b0;
        end else begin
            if (hready && hsel && htrans[1] && !hwrite &&
                haddr[7:0] == `TPU_ADDR_CHSC && chf_r) begin
                chf_arm_r <= 1'b1;
            end
            if (wr_chsc && !hwdata[`TPU_CH_FLAG] && chf_arm_r) begin
                chf_r     <= 1'b0;
                chf_arm_r <= 1'b0;
            end
        end
    end

    // ---------------- pins and interrupts ----------------
    // comparator routing takes the pin away from the timer entirely
    assign timer_owns = !comparator_to_capture_select_r && els_r != 2'h0;
    assign ch_pin_oe  = timer_owns ?
                        chmode != tpu_pkg::TPU_CH_CAPTURE : port_dir;
    assign ch_pin_o   = timer_owns ? chout_r : port_data;
    assign ovf_irq    = flag_r && toie_r;
    assign ch_irq     = chf_r && chie_r;

    // ---------------- assertions ----------------
    property p_comparator_to_capture_select_pin;
        @(posedge ref_clk) disable iff (!rst_n)
        comparator_to_capture_select_r |-> !timer_owns && ch_pin_oe == port_dir;
    endproperty
    a_comparator_to_capture_select_pin: assert property (p_comparator_to_capture_select_pin)
        else $error("pin kept by timer under comparator routing");

    property p_no_clock;
        @(posedge ref_clk) disable iff (!rst_n)
        clks_r == 2'h0 && !wr_cnt |=> $stable(cnt_r);
    endproperty
    a_no_clock: assert property (p_no_clock)
        else $error("counter moved with no clock selected");

    property p_wrap;
        @(posedge ref_clk) disable iff (!rst_n)
        tick && !center_aligned_pwm_r && !wr_cnt && cnt_r == top
        |=> cnt_r == 16'h0000 && flag_r;
    endproperty
    a_wrap: assert property (p_wrap)
        else $error("no wrap to zero with flag at modulus");

    property p_cnt_write;
        @(posedge ref_clk) disable iff (!rst_n)
        wr_cnt |=> cnt_r == 16'h0000;
    endproperty
    a_cnt_write: assert property (p_cnt_write)
        else $error("counter write did not clear the count");

    property p_free_run;
        @(posedge ref_clk) disable iff (!rst_n)
        mod_r == 16'h0000 && !center_aligned_pwm_r && tick && !wr_cnt &&
        cnt_r != 16'hffff |=> cnt_r == $past(cnt_r) + 16'h0001;
    endproperty
    a_free_run: assert property (p_free_run)
        else $error("zero modulus did not run free");

    property p_div_two;
        @(posedge ref_clk) disable iff (!rst_n)
        clks_r == 2'h1 && ps_r == 3'h1 && tick && !wr_cnt && !wr_sc
        ##1 !wr_sc && !wr_cnt |-> !tick ##1 tick;
    endproperty
    a_div_two: assert property (p_div_two)
        else $error("divide by two spacing wrong");

    property p_capture;
        @(posedge ref_clk) disable iff (!rst_n)
        cap_evt |=> chval_r == $past(cnt_r) && chf_r;
    endproperty
    a_capture: assert property (p_capture)
        else $error("capture did not latch count and flag");

    property p_idle_pin;
        @(posedge ref_clk) disable iff (!rst_n)
        els_r == 2'h0 |-> ch_pin_oe == port_dir && ch_pin_o == port_data;
    endproperty
    a_idle_pin: assert property (p_idle_pin)
        else $error("unused channel did not release the pin");
endmodule
`default_nettype wire

// >>> testbench/tpu_pin_model.sv
// far-side model: external count clock, fixed clock and channel pin
`timescale 1ns/1ps
`default_nettype none
module tpu_pin_model (
    input  wire logic ref_clk,     // bus clock
    input  wire logic ext_run,     // external clock runs while high
    input  wire logic lvl,         // level the far side puts on the pin
    input  wire logic ch_pin_o,    // timer pin drive
    input  wire logic ch_pin_oe,   // timer pin enable
    output logic      ext_clk_pin, // external count clock
    output logic      fixed_clk,   // fixed system clock
    output logic      ch_pin_i     // resolved pin level
);
    int n;
    initial begin
        n = 0;
        ext_clk_pin = 1'b0;
        fixed_clk = 1'b0;
    end
    // eighth of bus rate, inside the quarter-rate ceiling; stands still
    // outside a run so no stray edges are counted
    always @(posedge ref_clk) begin
        n <= n + 1;
        if (ext_run)
            ext_clk_pin <= n[2];
        fixed_clk <= (n % 10) < 5;
    end
    // no pull on the pin: whoever enables drives it
    assign ch_pin_i = ch_pin_oe ? ch_pin_o : lvl;
endmodule
`default_nettype wire

// >>> testbench/testbench.sv
// self-checking bench for the timer and PWM unit
`timescale 1ns/1ps
`default_nettype none
`include "tpu_map.svh"
module testbench;
    logic        ref_clk, rst_n, hsel, hwrite, cmp_out;
    logic [31:0] haddr, hwdata, hrdata, d, c1, c2, dl;
    logic [1:0]  htrans;
    logic [2:0]  hsize;
    logic        hrdy, hresp, port_data, port_dir, o, oe, owns;
    logic        ovf_irq, ch_irq, ext_run, lvl, ext_pin, fix_clk, pin_i;
    logic [1:0]  e;
    int          fails, num_checks, k, w, hi;

    tpu_timer_pwm dut_u (.ref_clk(ref_clk), .rst_n(rst_n), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
        .hwdata(hwdata), .hready(hrdy), .hrdata(hrdata),
        .hreadyout(hrdy), .hresp(hresp), .ext_clk_pin(ext_pin),
        .fixed_clk(fix_clk), .cmp_out(cmp_out), .ch_pin_i(pin_i),
        .ch_pin_o(o), .ch_pin_oe(oe), .port_data(port_data),
        .port_dir(port_dir), .timer_owns(owns), .ovf_irq(ovf_irq),
        .ch_irq(ch_irq));
    tpu_pin_model pm_u (.ref_clk(ref_clk), .ext_run(ext_run), .lvl(lvl),
        .ch_pin_o(o), .ch_pin_oe(oe), .ext_clk_pin(ext_pin),
        .fixed_clk(fix_clk), .ch_pin_i(pin_i));

    initial ref_clk = 1'b0;
    always #2.5 ref_clk = ~ref_clk;

    task finish_test;
        if (fails == 0 && num_checks > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    task chk(input logic [31:0] s, input logic [31:0] x);
        num_checks++;
        if (s !== x) begin
            fails++;
            $display("mismatch at %0t: got %h want %h", $time, s, x);
        end
    endtask
    task ok(input logic c);
        chk({31'h0, c}, 32'h1);
    endtask
    task wait_rdy;
        @(posedge ref_clk);
        while (hrdy !== 1'b1)
            @(posedge ref_clk);
    endtask
    task xfer(input logic [7:0] a, input logic wr, input logic [31:0] v);
        hsel <= 1'b1;
        haddr <= {24'h0, a};
        htrans <= 2'h2;
        hwrite <= wr;
        wait_rdy;
        htrans <= 2'h0;
        hsel <= 1'b0;
        hwdata <= v;
        wait_rdy;
        d = hrdata;
    endtask
    task wr(input logic [7:0] a, input logic [31:0] v);
        xfer(a, 1'b1, v);
    endtask
    task rd(input logic [7:0] a);
        xfer(a, 1'b0, 32'h0);
    endtask
    // clear a pending channel flag, then make one edge and look at it
    task edge_flag(input logic p, input logic c, input logic want);
        rd(`TPU_ADDR_CHSC);
        wr(`TPU_ADDR_CHSC, {28'h0, e, 2'h0});
        lvl <= p;
        cmp_out <= c;
        repeat (6) @(posedge ref_clk);
        rd(`TPU_ADDR_CHSC);
        chk({31'h0, d[7]}, {31'h0, want});
    endtask

    initial begin
        #200us;
        fails++;
        finish_test;
    end

    initial begin
        fails = 0;
        num_checks = 0;
        rst_n = 1'b0;
        hsel = 1'b0;
        haddr = 32'h0;
        htrans = 2'h0;
        hwrite = 1'b0;
        hsize = 3'h2;
        hwdata = 32'h0;
        cmp_out = 1'b0;
        port_data = 1'b1;
        port_dir = 1'b0;
        ext_run = 1'b0;
        lvl = 1'b1;
        e = 2'h0;
        repeat (16) @(posedge ref_clk);
        rst_n <= 1'b1;
        for (k = 0; k < 6; k++) begin
            rd(8'(k * 4));
            chk(d, 32'h0);
        end
        chk({31'h0, oe}, 32'h0);
        chk({31'h0, owns}, 32'h0);
        chk({31'h0, o}, {31'h0, port_data});
        wr(`TPU_ADDR_SC, 32'h08);
        repeat (50) @(posedge ref_clk);
        wr(`TPU_ADDR_SC, 32'h00);
        rd(`TPU_ADDR_CNT);
        c1 = d;
        rd(`TPU_ADDR_CNT);
        chk(d, c1);
        chk({31'h0, hresp}, 32'h0);
        ok(c1 > 32'd40);
        wr(`TPU_ADDR_CNT, 32'ha5a5);
        rd(`TPU_ADDR_CNT);
        chk(d, 32'h0);
        // every divisor: count over a fixed span of bus cycles
        for (k = 0; k < 8; k++) begin
            wr(`TPU_ADDR_SC, 32'h08 | k);
            rd(`TPU_ADDR_CNT);
            c1 = d;
            // the two reads sample 1024 edges apart, a multiple of 128
            repeat (1022) @(posedge ref_clk);
            rd(`TPU_ADDR_CNT);
            dl = ((d - c1) & 32'hffff) << k;
            chk(dl, 32'd1024);
        end
        // fixed clock has a period of 10, the external pin of 8
        for (k = 2; k < 4; k++) begin
            wr(`TPU_ADDR_SC, 32'h0);
            wr(`TPU_ADDR_CNT, 32'h0);
            ext_run <= 1'b1;
            wr(`TPU_ADDR_SC, 32'(k << 3));
            repeat (800) @(posedge ref_clk);
            wr(`TPU_ADDR_SC, 32'h0);
            ext_run <= 1'b0;
            rd(`TPU_ADDR_CNT);
            hi = (k == 3) ? 100 : 80;
            ok(d + 2 >= hi && d <= hi + 2);
        end
        wr(`TPU_ADDR_MOD, 32'h1);
        wr(`TPU_ADDR_CNT, 32'h0);
        wr(`TPU_ADDR_SC, 32'h4f);
        w = 0;
        while (ovf_irq !== 1'b1 && w < 600) begin
            @(posedge ref_clk);
            w++;
        end
        rd(`TPU_ADDR_SC);
        chk(d, 32'hcf);
        wr(`TPU_ADDR_SC, 32'h4f);
        rd(`TPU_ADDR_SC);
        chk(d, 32'h4f);
        chk({31'h0, ovf_irq}, 32'h0);
        rd(`TPU_ADDR_CNT);
        ok(d <= 32'h1);
        // center mode: count must turn down and never exceed the modulus
        wr(`TPU_ADDR_MOD, 32'h5);
        wr(`TPU_ADDR_SC, 32'h28);
        wr(`TPU_ADDR_CHSC, 32'h08);
        @(posedge ref_clk);
        chk({31'h0, oe}, 32'h1);
        c1 = 0;
        hi = 0;
        for (k = 0; k < 20; k++) begin
            rd(`TPU_ADDR_CNT);
            ok(d <= 32'h5);
            if (d < c1)
                hi = 1;
            c1 = d;
        end
        chk(32'(hi), 32'h1);
        wr(`TPU_ADDR_SC, 32'h0);
        // compare: set, clear, toggle against a modulus of 9
        port_data <= 1'b0;
        wr(`TPU_ADDR_MOD, 32'h9);
        wr(`TPU_ADDR_SC, 32'h08);
        for (k = 3; k > 0; k--) begin
            wr(`TPU_ADDR_CHSC, 32'h50 | (k << 2));
            wr(`TPU_ADDR_CHVAL, 32'h5);
            repeat (25) @(posedge ref_clk);
            ok(owns === 1'b1 && oe === 1'b1 && ch_irq === 1'b1);
            if (k > 1)
                chk({31'h0, o}, 32'(k == 3));
            else begin
                c1 = {31'h0, o};
                w = 0;
                while (o === c1[0] && w < 12) begin
                    @(posedge ref_clk);
                    w++;
                end
                ok(o !== c1[0]);
            end
        end
        // edge PWM, duty 4 of 10, both polarities
        wr(`TPU_ADDR_CHVAL, 32'h4);
        for (k = 1; k < 3; k++) begin
            wr(`TPU_ADDR_CHSC, 32'h20 | (k << 2));
            repeat (20) @(posedge ref_clk);
            hi = 0;
            repeat (100) begin
                @(posedge ref_clk);
                hi += int'(o);
            end
            chk(32'(hi), (k == 2) ? 32'd40 : 32'd60);
        end
        wr(`TPU_ADDR_MOD, 32'h0);
        // leave pwm first so no duty match disturbs the flag clearing
        wr(`TPU_ADDR_CHSC, 32'h0);
        for (k = 1; k < 4; k++) begin
            e = 2'(k);
            edge_flag(1'b0, 1'b0, e[1]);
            edge_flag(1'b1, 1'b0, e[0]);
        end
        // comparator takes over capture and the pin goes back to the port
        port_dir <= 1'b1;
        e = 2'h1;
        wr(`TPU_ADDR_OPT2, 32'h1);
        @(posedge ref_clk);
        ok(owns === 1'b0 && oe === 1'b1);
        edge_flag(1'b0, 1'b1, 1'b1);
        edge_flag(1'b1, 1'b1, 1'b0);
        finish_test;
    end
endmodule
`default_nettype wire
